// [rtl/irq_entry_pkg.sv]
`default_nettype none
package irq_entry_pkg;
    // =====================================================
    // widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int PC_W = 13;
    localparam int NUM_CORE = 3;
    localparam int NUM_PERIPH = 8;
    localparam int STACK_DEPTH = 8;

    // =====================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PFLAG = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_PENABLE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;

    // =====================================================
    // field positions of irq_control_reg
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PGIE = 6;
    localparam int CORE_EN_LSB = 3;
    localparam int CORE_FLAG_LSB = 0;

    // field positions of the status register
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_PEND_BIT = 2;
    localparam int STAT_DEPTH_LSB = 4;

    // =====================================================
    // reset values
    localparam logic [NUM_CORE-1:0] CORE_RESET = 3'h0;
    localparam logic [NUM_PERIPH-1:0] PERIPH_RESET = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

    // fixed entry address
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

    // instruction cycles from the sampled cycle to vector start
    localparam int LAT_SYNC_MIN = 3;
    localparam int LAT_SYNC_MAX = 4;
    localparam int LAT_ASYNC_MAX = 5;
    localparam logic [2:0] ENTRY_TICKS = 3'h2;

    // =====================================================
    // types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FLUSH = 2'b01,
        ST_PUSH = 2'b11,
        ST_VECTOR = 2'b10
    } entry_state_type;

    typedef struct packed {
        logic flush;
        logic push;
        logic load_pc;
        logic [PC_W-1:0] pc;
    } core_cmd_type;

    localparam core_cmd_type CMD_IDLE = '{1'b0, 1'b0, 1'b0, PC_RESET};
endpackage
`default_nettype wire

// [rtl/return_stack.sv]
`timescale 1ns/1ns
`default_nettype none
module return_stack
    import irq_entry_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] top_data,
    output logic [$clog2(DEPTH):0] depth
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] ptr_q;
    logic [PW:0] depth_q;
    logic [PW-1:0] top_idx;

    // circular: overflow overwrites the oldest entry
    assign top_idx = ptr_q - {{(PW-1){1'b0}}, 1'b1};
    assign top_data = mem_q[top_idx];
    assign depth = depth_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= '0;
            depth_q <= '0;
        end else if (push) begin
            ptr_q <= ptr_q + {{(PW-1){1'b0}}, 1'b1};
            if (depth_q != DEPTH[PW:0]) begin
                depth_q <= depth_q + {{PW{1'b0}}, 1'b1};
            end
        end else if (pop) begin
            ptr_q <= top_idx;
            if (depth_q != '0) begin
                depth_q <= depth_q - {{PW{1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[ptr_q] <= push_data;
        end
    end
endmodule // return_stack
`default_nettype wire

// [rtl/interrupt_entry_control.sv]
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module interrupt_entry_control
    import irq_entry_pkg::*;
#(
    parameter int N_PERIPH = NUM_PERIPH,
    parameter int N_STACK = STACK_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // event sources
    input wire logic [NUM_CORE-1:0] core_event,
    input wire logic [N_PERIPH-1:0] periph_event,
    // core sequencer
    input wire logic instr_tick,
    input wire logic return_from_irq_instruction,
    input wire logic [PC_W-1:0] pc_in,
    output core_cmd_type core_cmd,
    output logic irq_request,
    output logic in_service
);
    // =====================================================
    // reset release
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // =====================================================
    // functions
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic any_enabled(input logic [N_PERIPH-1:0] f,
                                         input logic [N_PERIPH-1:0] e);
        any_enabled = |(f & e);
    endfunction

    // =====================================================
    // state
    logic global_irq_enable_q, global_irq_enable_d;
    logic peripheral_group_irq_enable_q, peripheral_group_irq_enable_d;
    logic [NUM_CORE-1:0] core_en_q, core_en_d;
    logic [NUM_CORE-1:0] core_flag_q, core_flag_d;
    logic [N_PERIPH-1:0] peripheral_flag_reg_q, peripheral_flag_reg_d;
    logic [N_PERIPH-1:0] peripheral_enable_reg_q, peripheral_enable_reg_d;
    entry_state_type state_q, state_d;
    core_cmd_type cmd_q, cmd_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    // =====================================================
    // register decode
    wire wr_control = wr && hit(addr, OFS_CONTROL);
    wire wr_pflag = wr && hit(addr, OFS_PFLAG);
    wire wr_penable = wr && hit(addr, OFS_PENABLE);

    logic [PC_W-1:0] stack_top;
    logic [$clog2(N_STACK):0] stack_depth;

    wire [DATA_W-1:0] control_view = {global_irq_enable_q,
        peripheral_group_irq_enable_q, core_en_q, core_flag_q};
    wire [DATA_W-1:0] status_view = DATA_W'({stack_depth, 1'b0,
        irq_request, state_q});

    // =====================================================
    // request forming
    wire core_pending = |(core_flag_q & core_en_q);
    wire periph_pending = peripheral_group_irq_enable_q &&
        any_enabled(peripheral_flag_reg_q, peripheral_enable_reg_q);
    wire pending_any = core_pending || periph_pending;
    assign irq_request = global_irq_enable_q && pending_any;

    wire take_irq = (state_q == ST_IDLE) && instr_tick && irq_request;
    wire do_return = (state_q == ST_IDLE) && !take_irq &&
        return_from_irq_instruction;
    wire do_push = (state_q == ST_FLUSH) && instr_tick;

    // =====================================================
    // next values of the registers
    always_comb begin
        // flags: a set in the clearing cycle wins
        core_flag_d = (wr_control ? wdata[CORE_FLAG_LSB +: NUM_CORE]
            : core_flag_q) | core_event;
        peripheral_flag_reg_d = (wr_pflag ? wdata[N_PERIPH-1:0]
            : peripheral_flag_reg_q) | periph_event;
        core_en_d = wr_control ? wdata[CORE_EN_LSB +: NUM_CORE] : core_en_q;
        peripheral_enable_reg_d = wr_penable ? wdata[N_PERIPH-1:0]
            : peripheral_enable_reg_q;
        peripheral_group_irq_enable_d = wr_control ? wdata[BIT_PGIE]
            : peripheral_group_irq_enable_q;
        global_irq_enable_d = global_irq_enable_q;
        if (take_irq) begin
            global_irq_enable_d = 1'b0;
        end else if (do_return) begin
            global_irq_enable_d = 1'b1;
        end else if (wr_control) begin
            global_irq_enable_d = wdata[BIT_GLOBAL_EN];
        end
    end

    // =====================================================
    // entry sequencer
    always_comb begin
        state_d = state_q;
        cmd_d = CMD_IDLE;
        case (state_q)
            ST_IDLE: begin
                if (take_irq) begin
                    state_d = ST_FLUSH;
                    cmd_d.flush = 1'b1;
                end else if (do_return) begin
                    cmd_d.load_pc = 1'b1;
                    cmd_d.pc = stack_top;
                end
            end
            ST_FLUSH: begin
                if (instr_tick) begin
                    state_d = ST_PUSH;
                    cmd_d.push = 1'b1;
                    cmd_d.pc = pc_in;
                end
            end
            ST_PUSH: begin
                if (instr_tick) begin
                    state_d = ST_VECTOR;
                    cmd_d.load_pc = 1'b1;
                    cmd_d.pc = IRQ_VECTOR;
                end
            end
            ST_VECTOR: begin
                if (instr_tick) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // =====================================================
    // read path
    always_comb begin
        rdata_d = RDATA_RESET;
        if (rd) begin
            case (addr)
                OFS_CONTROL: rdata_d = control_view;
                OFS_PFLAG: rdata_d = DATA_W'(peripheral_flag_reg_q);
                OFS_PENABLE: rdata_d = DATA_W'(peripheral_enable_reg_q);
                OFS_STATUS: rdata_d = status_view;
                default: rdata_d = RDATA_RESET;
            endcase
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            global_irq_enable_q <= 1'b0;
            peripheral_group_irq_enable_q <= 1'b0;
            core_en_q <= CORE_RESET;
            core_flag_q <= CORE_RESET;
            peripheral_flag_reg_q <= N_PERIPH'(PERIPH_RESET);
            peripheral_enable_reg_q <= N_PERIPH'(PERIPH_RESET);
        end else begin
            global_irq_enable_q <= global_irq_enable_d;
            peripheral_group_irq_enable_q <= peripheral_group_irq_enable_d;
            core_en_q <= core_en_d;
            core_flag_q <= core_flag_d;
            peripheral_flag_reg_q <= peripheral_flag_reg_d;
            peripheral_enable_reg_q <= peripheral_enable_reg_d;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= ST_IDLE;
            cmd_q <= CMD_IDLE;
            rdata_q <= RDATA_RESET;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign core_cmd = cmd_q;
    assign in_service = (state_q != ST_IDLE);

    // =====================================================
    // return address stack
    return_stack #(
        .DEPTH(N_STACK),
        .WIDTH(PC_W)
    ) u_stack (
        .clk(clk),
        .rst_n(rst_sync_q),
        .push(do_push),
        .pop(do_return),
        .push_data(pc_in),
        .top_data(stack_top),
        .depth(stack_depth)
    );

    // =====================================================
    // checks
    logic [2:0] lat_cnt_q;

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            lat_cnt_q <= 3'h0;
        end else if (state_q == ST_IDLE) begin
            lat_cnt_q <= 3'h0;
        end else if (instr_tick) begin
            lat_cnt_q <= lat_cnt_q + 3'h1;
        end
    end

    AST_RESET_DISABLED: assert property (
        @(posedge clk) !rst_sync_q |-> !global_irq_enable_q && !irq_request)
        else $error("global enable set during reset");

    AST_TAKE_NEEDS_ENABLE: assert property (
        @(posedge clk) disable iff (!rst_sync_q)
        (state_q == ST_IDLE) ##1 (state_q == ST_FLUSH)
        |-> $past(global_irq_enable_q) && $past(pending_any))
        else $error("entry without enabled pending flag");

    AST_FLAG_SETS: assert property (
        @(posedge clk) disable iff (!rst_sync_q)
        core_event != '0
        |=> (core_flag_q & $past(core_event)) == $past(core_event))
        else $error("event did not set its flag");

    AST_ENTRY_FLUSH: assert property (
        @(posedge clk) disable iff (!rst_sync_q)
        take_irq |=> cmd_q.flush && !global_irq_enable_q)
        else $error("entry did not flush and clear global enable");

    AST_ENTRY_PUSH_VECTOR: assert property (
        @(posedge clk) disable iff (!rst_sync_q)
        (state_q == ST_PUSH && instr_tick)
        |=> cmd_q.load_pc && cmd_q.pc == IRQ_VECTOR)
        else $error("vector not loaded after push");

    AST_NO_NESTING: assert property (
        @(posedge clk) disable iff (!rst_sync_q)
        (state_q != ST_IDLE) |-> !cmd_q.push || !global_irq_enable_q)
        else $error("global enable set while in service");

    AST_RETURN: assert property (
        @(posedge clk) disable iff (!rst_sync_q)
        do_return |=> global_irq_enable_q && cmd_q.load_pc
        && cmd_q.pc == $past(stack_top))
        else $error("return did not pop and re-enable");

    AST_GLOBAL_OFF_BLOCKS: assert property (
        @(posedge clk) disable iff (!rst_sync_q)
        (state_q == ST_IDLE && !global_irq_enable_q) |=> state_q == ST_IDLE)
        else $error("vectoring with global enable clear");

    AST_LATENCY: assert property (
        @(posedge clk) disable iff (!rst_sync_q)
        (state_q == ST_VECTOR && instr_tick) |-> lat_cnt_q == ENTRY_TICKS)
        else $error("entry latency off");
endmodule // interrupt_entry_control
`default_nettype wire

// [tb/core_seq_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// core sequencer: instruction ticks, pc, return
module core_seq_model
    import irq_entry_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire core_cmd_type core_cmd,
    input wire logic in_service,
    input wire logic ret_req,
    output logic instr_tick,
    output logic ret_pulse,
    output logic [PC_W-1:0] pc
);
    logic [1:0] div_q;

    // one instruction cycle every four clocks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 2'h0;
            instr_tick <= 1'b0;
            ret_pulse <= 1'b0;
            pc <= 13'h0100;
        end else begin
            div_q <= div_q + 2'h1;
            instr_tick <= (div_q == 2'h3);
            ret_pulse <= ret_req;
            // pc stalls on flushed cycles
            if (core_cmd.load_pc) begin
                pc <= core_cmd.pc;
            end else if (instr_tick && !in_service) begin
                pc <= pc + 13'h0001;
            end
        end
    end
endmodule // core_seq_model
`default_nettype wire

// [tb/test_interrupt_entry_control.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_interrupt_entry_control
    import irq_entry_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ret_req = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, rv;
    logic [NUM_CORE-1:0] core_event = '0;
    logic [NUM_PERIPH-1:0] periph_event = '0;
    logic instr_tick, ret_pulse, irq_request, in_service;
    logic [PC_W-1:0] pc_in, push_pc, exp_push, load_v;
    core_cmd_type core_cmd;
    int err_total = 0, n_checks = 0, n_tick = 0, n_flush = 0, n_load = 0;
    int f0, t0;

    always #2 clk = ~clk;

    interrupt_entry_control i_interrupt_entry_control (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .core_event(core_event),
        .periph_event(periph_event), .instr_tick(instr_tick),
        .return_from_irq_instruction(ret_pulse), .pc_in(pc_in),
        .core_cmd(core_cmd), .irq_request(irq_request),
        .in_service(in_service));
    core_seq_model i_core_seq_model (
        .clk(clk), .rst_n(rst_n), .core_cmd(core_cmd),
        .in_service(in_service), .ret_req(ret_req),
        .instr_tick(instr_tick), .ret_pulse(ret_pulse), .pc(pc_in));

    // ==========================================
    // monitor of core commands
    always @(posedge clk) begin
        if (instr_tick) n_tick++;
        if (core_cmd.flush) n_flush++;
        if (core_cmd.push) begin
            push_pc = core_cmd.pc;
            exp_push = pc_in;
        end
        if (core_cmd.load_pc) begin
            load_v = core_cmd.pc;
            n_load++;
        end
    end

    // ==========================================
    // bus and helper tasks
    task end_of_test;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task rd_reg(input logic [ADDR_W-1:0] a);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task pulse_ev(input logic [NUM_CORE-1:0] c, input logic [7:0] p);
        @(posedge clk); core_event <= c; periph_event <= p;
        @(posedge clk); core_event <= '0; periph_event <= '0;
    endtask
    task wait_load;
        int k0;
        k0 = n_load;
        for (int i = 0; i < 100 && n_load == k0; i++) @(negedge clk);
    endtask
    task do_return;
        @(posedge clk); ret_req <= 1'b1;
        @(posedge clk); ret_req <= 1'b0;
        wait_load;
    endtask

    // ==========================================
    // scenarios
    task t_reset;
        rd_reg(OFS_CONTROL); `CHK(rv, 8'h00)
        rd_reg(OFS_PFLAG); `CHK(rv, 8'h00)
        rd_reg(OFS_PENABLE); `CHK(rv, 8'h00)
        `CHK(irq_request, 1'b0)
        $display("test reset done");
    endtask
    task t_flags;
        pulse_ev(3'h7, 8'hA5);
        rd_reg(OFS_CONTROL); `CHK(rv, 8'h07)
        rd_reg(OFS_PFLAG); `CHK(rv, 8'hA5)
        wr_reg(OFS_PENABLE, 8'hFF);
        wr_reg(OFS_CONTROL, 8'h7F);
        @(negedge clk); `CHK(irq_request, 1'b0)
        `CHK(n_flush, 0)
        wr_reg(OFS_CONTROL, 8'h00);
        wr_reg(OFS_PFLAG, 8'h00);
        rd_reg(OFS_PFLAG); `CHK(rv, 8'h00)
        $display("test flags done");
    endtask
    task t_group;
        wr_reg(OFS_PENABLE, 8'h10);
        pulse_ev(3'h0, 8'h10);
        wr_reg(OFS_CONTROL, 8'h80);
        f0 = n_flush;
        repeat (30) @(negedge clk);
        `CHK(irq_request, 1'b0)
        `CHK(n_flush, f0)
        wr_reg(OFS_CONTROL, 8'hC0);
        wait_load;
        `CHK(n_flush, f0 + 1)
        `CHK(load_v, IRQ_VECTOR)
        rd_reg(OFS_CONTROL); `CHK(rv, 8'h40)
        rd_reg(OFS_PFLAG); `CHK(rv, 8'h10)
        wr_reg(OFS_PFLAG, 8'h00);
        do_return;
        `CHK(load_v, push_pc)
        rd_reg(OFS_CONTROL); `CHK(rv, 8'hC0)
        f0 = n_flush;
        repeat (30) @(negedge clk);
        `CHK(n_flush, f0)
        wr_reg(OFS_CONTROL, 8'h00);
        $display("test group done");
    endtask
    task t_entry;
        wr_reg(OFS_CONTROL, 8'h98);
        @(posedge clk iff instr_tick);
        core_event <= 3'h1;
        @(posedge clk);
        core_event <= 3'h0;
        @(negedge clk);
        t0 = n_tick;
        f0 = n_flush;
        wait_load;
        `CHK(load_v, IRQ_VECTOR)
        `CHK(push_pc, exp_push)
        `CHK(in_service, 1'b1)
        @(posedge clk iff instr_tick);
        @(negedge clk);
        `CHK(in_service, 1'b0)
        `CHK(n_tick - t0 >= LAT_SYNC_MIN, 1'b1)
        `CHK(n_tick - t0 <= LAT_SYNC_MAX, 1'b1)
        rd_reg(OFS_STATUS); `CHK(rv[7:4], 4'h1)
        `CHK(rv[3:0], 4'h0)
        rd_reg(OFS_CONTROL); `CHK(rv, 8'h19)
        pulse_ev(3'h2, 8'h00);
        repeat (20) @(negedge clk);
        rd_reg(OFS_CONTROL); `CHK(rv, 8'h1B)
        `CHK(n_flush, f0 + 1)
        do_return;
        `CHK(load_v, push_pc)
        wait_load;
        `CHK(n_flush, f0 + 2)
        `CHK(load_v, IRQ_VECTOR)
        wr_reg(OFS_CONTROL, 8'h18);
        do_return;
        rd_reg(OFS_CONTROL); `CHK(rv, 8'h98)
        f0 = n_flush;
        repeat (30) @(negedge clk);
        `CHK(n_flush, f0)
        $display("test entry done");
    endtask
    task t_rerst;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(OFS_CONTROL);
        `CHK(rv, 8'h00)
        rd_reg(OFS_PENABLE);
        `CHK(rv, 8'h00)
        rd_reg(OFS_STATUS);
        `CHK(rv, 8'h00)
        `CHK(in_service, 1'b0)
        $display("test reset again done");
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_flags;
        t_group;
        t_entry;
        t_rerst;
        end_of_test;
    end
    initial begin
        #40000;
        err_total++;
        end_of_test;
    end
endmodule // test_interrupt_entry_control
`default_nettype wire
